// File: design/pse_pkg.sv
// Purpose: shared constants and types of the paging stream encoder
// Assumes: 50 MHz clock
// Notes:   register map and frame field sizes
package pse_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] pse_off_ctrl    = 8'h00;
    localparam logic [7:0] pse_off_config  = 8'h04;
    localparam logic [7:0] pse_off_address = 8'h08;
    localparam logic [7:0] pse_off_rate    = 8'h0c;
    localparam logic [7:0] pse_off_bursts  = 8'h10;
    localparam logic [7:0] pse_off_errbit  = 8'h14;
    localparam logic [7:0] pse_off_status  = 8'h18;
    localparam logic [7:0] pse_off_msg     = 8'h40;
    localparam int         pse_msg_chars   = 16;

    // ------------------------------------------------------------
    // control and config fields
    // ------------------------------------------------------------
    localparam int pse_ctrl_send_bit  = 0;
    localparam int pse_ctrl_stop_bit  = 1;
    localparam int pse_cfg_mode_lsb   = 0;
    localparam int pse_cfg_func_lsb   = 2;
    localparam int pse_cfg_type_lsb   = 4;
    localparam int pse_cfg_std_bit    = 6;
    localparam int pse_cfg_inv_bit    = 7;
    localparam int pse_cfg_errena_bit = 8;
    localparam int pse_cfg_len_lsb    = 12;

    // ------------------------------------------------------------
    // reset values and frame sizes
    // ------------------------------------------------------------
    localparam logic [15:0] pse_rate_reset    = 16'd1200;
    localparam logic [7:0]  pse_bursts_reset  = 8'h01;
    localparam int          pse_preamble_bits = 32;
    localparam int          pse_addr_bits     = 21;
    localparam int          pse_func_bits     = 2;
    localparam int          pse_clock_hz      = 50000000;

    typedef enum logic [1:0]
    {
        pse_mode_single = 2'b00,
        pse_mode_burst  = 2'b01,
        pse_mode_cont   = 2'b10
    } pse_mode_t;

    typedef enum logic [1:0]
    {
        pse_type_tone  = 2'b00,
        pse_type_num   = 2'b01,
        pse_type_alpha = 2'b10
    } pse_type_t;

    typedef enum logic [2:0]
    {
        pse_st_idle     = 3'b000,
        pse_st_preamble = 3'b001,
        pse_st_address  = 3'b010,
        pse_st_function = 3'b011,
        pse_st_message  = 3'b100
    } pse_state_t;
endpackage

// File: design/pse_fifo.sv
// Purpose: small flip-flop fifo with valid and ready on both sides
// Assumes: depth is a power of two
// Notes:   first word fall through
`timescale 1ns/10ps
module pse_fifo #(
    parameter int width = 8,
    parameter int depth = 4
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [width-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [width-1:0] out_data,
    input  wire logic             flush
);
    localparam int aw = $clog2(depth);

    logic [width-1:0] mem [depth];
    logic [aw-1:0]    wr_ptr;
    logic [aw-1:0]    rd_ptr;
    logic [aw:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign in_ready  = (count != (aw+1)'(depth));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign do_wr     = in_valid && in_ready;
    assign do_rd     = out_valid && out_ready;

    always_ff @(posedge clock)
    begin
        if (do_wr)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else if (flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
            if (do_wr && !do_rd)
                count <= count + 1'b1;
            else if (do_rd && !do_wr)
                count <= count - 1'b1;
        end
    end
endmodule // pse_fifo

// File: design/pse_encoder.sv
// Purpose: paging stream encoder: frame builder, repeat control, bit timing
// Assumes: one 50 MHz clock, register port with read data one cycle later
// Notes:   bits pass a 4-word fifo before the bit-rate output stage
`timescale 1ns/10ps
module pse_encoder #(
    parameter int fifo_depth = 4
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    output logic             out_active,
    output logic             out_positive,
    output logic             out_negative,
    output logic             bit_strobe,
    output logic             sending
);
    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [1:0]  mode;
    logic [1:0]  func;
    logic [1:0]  ptype;
    logic        std_gsc;
    logic        invert;
    logic        err_ena;
    logic [4:0]  msg_len;
    logic [20:0] pager_code;
    logic [15:0] rate;
    logic [7:0]  bursts;
    logic [15:0] err_pos;
    logic [7:0]  msg [pse_pkg::pse_msg_chars];
    logic        send_req;
    logic        stop_req;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode       <= 2'h0;
            func       <= 2'h0;
            ptype      <= 2'h0;
            std_gsc    <= 1'b0;
            invert     <= 1'b0;
            err_ena    <= 1'b0;
            msg_len    <= 5'h00;
            pager_code <= 21'h000000;
            rate       <= pse_pkg::pse_rate_reset;
            bursts     <= pse_pkg::pse_bursts_reset;
            err_pos    <= 16'h0000;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                pse_pkg::pse_off_config:
                begin
                    mode    <= reg_wdata[pse_pkg::pse_cfg_mode_lsb +: 2];
                    func    <= reg_wdata[pse_pkg::pse_cfg_func_lsb +: 2];
                    ptype   <= reg_wdata[pse_pkg::pse_cfg_type_lsb +: 2];
                    std_gsc <= reg_wdata[pse_pkg::pse_cfg_std_bit];
                    invert  <= reg_wdata[pse_pkg::pse_cfg_inv_bit];
                    err_ena <= reg_wdata[pse_pkg::pse_cfg_errena_bit];
                    msg_len <= reg_wdata[pse_pkg::pse_cfg_len_lsb +: 5];
                end
                pse_pkg::pse_off_address: pager_code <= reg_wdata[20:0];
                pse_pkg::pse_off_rate:    rate       <= reg_wdata[15:0];
                pse_pkg::pse_off_bursts:  bursts     <= reg_wdata[7:0];
                pse_pkg::pse_off_errbit:  err_pos    <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < pse_pkg::pse_msg_chars; gi++)
        begin : g_msg
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                    msg[gi] <= 8'h00;
                else if (reg_write && reg_addr == pse_pkg::pse_off_msg + 8'(4*gi))
                    msg[gi] <= reg_wdata[7:0];
            end
        end
    endgenerate

    assign send_req = reg_write && reg_addr == pse_pkg::pse_off_ctrl
                      && reg_wdata[pse_pkg::pse_ctrl_send_bit];
    assign stop_req = reg_write && reg_addr == pse_pkg::pse_off_ctrl
                      && reg_wdata[pse_pkg::pse_ctrl_stop_bit];

    // ------------------------------------------------------------
    // frame builder
    // ------------------------------------------------------------
    pse_pkg::pse_state_t state;
    logic [7:0]  idx;
    logic [4:0]  chr;
    logic [7:0]  reps_left;
    logic [15:0] bit_pos;
    logic        stop_pending;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic        fifo_out_data;
    logic        gen_bit;
    logic        raw_bit;
    logic        has_msg;
    logic        last_bit;
    logic        frame_end;
    logic        more_reps;
    logic [7:0]  cur_char;
    logic [4:0]  eff_len;

    assign has_msg  = (ptype == pse_pkg::pse_type_num) || (ptype == pse_pkg::pse_type_alpha);
    // length capped at the message store
    assign eff_len  = (msg_len > 5'(pse_pkg::pse_msg_chars)) ? 5'(pse_pkg::pse_msg_chars)
                                                             : msg_len;
    assign cur_char = msg[chr[3:0]];

    always_comb
    begin
        raw_bit  = 1'b0;
        last_bit = 1'b0;
        case (state)
            pse_pkg::pse_st_preamble:
            begin
                // gsc preamble is inverse phase of pocsag
                raw_bit  = idx[0] ^ std_gsc;
                last_bit = (idx == 8'(pse_pkg::pse_preamble_bits - 1));
            end
            pse_pkg::pse_st_address:
            begin
                raw_bit  = pager_code[5'(pse_pkg::pse_addr_bits - 1) - idx[4:0]];
                last_bit = (idx == 8'(pse_pkg::pse_addr_bits - 1));
            end
            pse_pkg::pse_st_function:
            begin
                raw_bit  = func[1 - idx[0]];
                last_bit = (idx == 8'(pse_pkg::pse_func_bits - 1));
            end
            pse_pkg::pse_st_message:
            begin
                // numeric sends 4-bit digits, alpha 7-bit characters
                raw_bit  = cur_char[idx[2:0]];
                last_bit = (ptype == pse_pkg::pse_type_num) ? (idx == 8'h03)
                                                              : (idx == 8'h06);
            end
            default: ;
        endcase
    end

    assign gen_bit   = raw_bit ^ (err_ena && bit_pos == err_pos);
    assign frame_end = last_bit && fifo_in_ready && (
        (state == pse_pkg::pse_st_function && !(has_msg && eff_len != 5'h00)) ||
        (state == pse_pkg::pse_st_message && chr == eff_len - 5'h01));
    // burst count only in burst mode
    assign more_reps = !stop_pending && !stop_req && (
        (mode == pse_pkg::pse_mode_cont) ||
        (mode == pse_pkg::pse_mode_burst && reps_left > 8'h01));

    // preamble, address, function, message in order
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state     <= pse_pkg::pse_st_idle;
            idx       <= 8'h00;
            chr       <= 5'h00;
            reps_left <= 8'h00;
            bit_pos   <= 16'h0000;
        end
        else if (state == pse_pkg::pse_st_idle)
        begin
            if (send_req && !stop_req)
            begin
                state     <= pse_pkg::pse_st_preamble;
                idx       <= 8'h00;
                chr       <= 5'h00;
                bit_pos   <= 16'h0000;
                // single or cont start with one pending frame
                reps_left <= (mode == pse_pkg::pse_mode_burst) ? bursts : 8'h01;
            end
        end
        else if (stop_req)
            state <= pse_pkg::pse_st_idle;
        else if (fifo_in_ready)
        begin
            bit_pos <= bit_pos + 16'h0001;
            idx     <= last_bit ? 8'h00 : idx + 8'h01;
            if (frame_end)
            begin
                bit_pos <= 16'h0000;
                chr     <= 5'h00;
                if (more_reps)
                begin
                    state <= pse_pkg::pse_st_preamble;
                    if (mode == pse_pkg::pse_mode_burst)
                        reps_left <= reps_left - 8'h01;
                end
                else
                    state <= pse_pkg::pse_st_idle;
            end
            else if (last_bit)
            begin
                case (state)
                    pse_pkg::pse_st_preamble: state <= pse_pkg::pse_st_address;
                    pse_pkg::pse_st_address:  state <= pse_pkg::pse_st_function;
                    pse_pkg::pse_st_function: state <= pse_pkg::pse_st_message;
                    pse_pkg::pse_st_message:  chr   <= chr + 5'h01;
                    default:                  state <= pse_pkg::pse_st_idle;
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            stop_pending <= 1'b0;
        else if (state == pse_pkg::pse_st_idle)
            stop_pending <= 1'b0;
        else if (stop_req)
            stop_pending <= 1'b1;
    end

    // ------------------------------------------------------------
    // bit fifo and rate divider
    // ------------------------------------------------------------
    logic [31:0] div_cnt;
    logic [31:0] div_max;
    logic        tick;
    logic        out_bit;
    logic        fifo_pop;

    // cycles per bit from the rate setting
    assign div_max  = (rate == 16'h0000) ? 32'h0
                    : 32'(pse_pkg::pse_clock_hz) / {16'h0000, rate} - 32'h1;
    assign tick     = (div_cnt >= div_max);
    assign fifo_pop = tick && fifo_out_valid;

    pse_fifo #(
        .width (1),
        .depth (fifo_depth)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (state != pse_pkg::pse_st_idle && !stop_req),
        .in_ready  (fifo_in_ready),
        .in_data   (gen_bit),
        .out_valid (fifo_out_valid),
        .out_ready (tick),
        .out_data  (fifo_out_data),
        .flush     (stop_req)
    );

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt <= 32'h0;
        else if (tick || stop_req)
            div_cnt <= 32'h0;
        else
            div_cnt <= div_cnt + 32'h1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_active <= 1'b0;
            out_bit    <= 1'b0;
            bit_strobe <= 1'b0;
        end
        else
        begin
            bit_strobe <= fifo_pop && !stop_req;
            if (stop_req)
                out_active <= 1'b0;
            else if (tick)
            begin
                out_active <= fifo_out_valid;
                out_bit    <= fifo_out_data;
            end
        end
    end

    // polarity mapping, equal magnitude either way
    assign out_positive = out_active && (out_bit ^ invert);
    assign out_negative = out_active && !(out_bit ^ invert);

    // busy while frames run or bits still drain
    assign sending = (state != pse_pkg::pse_st_idle) || fifo_out_valid || out_active;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0;
        else if (reg_read)
        begin
            reg_rdata <= 32'h0;
            case (reg_addr)
                pse_pkg::pse_off_config:
                    reg_rdata <= {15'h0, msg_len, 3'h0, err_ena, invert, std_gsc,
                                  ptype, func, mode};
                pse_pkg::pse_off_address: reg_rdata <= {11'h0, pager_code};
                pse_pkg::pse_off_rate:    reg_rdata <= {16'h0, rate};
                pse_pkg::pse_off_bursts:  reg_rdata <= {24'h0, bursts};
                pse_pkg::pse_off_errbit:  reg_rdata <= {16'h0, err_pos};
                pse_pkg::pse_off_status:  reg_rdata <= {23'h0, reps_left, sending};
                default:
                    if (reg_addr >= pse_pkg::pse_off_msg && reg_addr[1:0] == 2'h0 &&
                        reg_addr < pse_pkg::pse_off_msg + 8'(4*pse_pkg::pse_msg_chars))
                        reg_rdata <= {24'h0, msg[reg_addr[5:2]]};
            endcase
        end
    end
endmodule // pse_encoder

// File: verif/pse_encoder_checker.sv
// Purpose: port-level assertions for the paging stream encoder
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every pse_encoder instance
`timescale 1ns/10ps
module pse_encoder_checker #(
    parameter int fifo_depth = 4
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        out_active,
    input wire logic        out_positive,
    input wire logic        out_negative,
    input wire logic        bit_strobe,
    input wire logic        sending
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // request and idle sequences
    // ------------------------------------------------------------
    sequence send_req;
        reg_write && reg_addr == pse_pkg::pse_off_ctrl && reg_wdata[1:0] == 2'b01;
    endsequence
    sequence stop_req;
        reg_write && reg_addr == pse_pkg::pse_off_ctrl && reg_wdata[1:0] == 2'b10;
    endsequence
    sequence quiet;
        !sending && !out_active;
    endsequence

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    level_excl_a: assert property (!(out_positive && out_negative))
        else $error("both output levels high");
    idle_level_a: assert property (!out_active |-> !out_positive && !out_negative)
        else $error("level driven while inactive");
    active_level_a: assert property (out_active |-> out_positive != out_negative)
        else $error("no level while active");
    strobe_bit_a: assert property (bit_strobe |-> out_active)
        else $error("strobe without a loaded bit");
    active_busy_a: assert property (out_active |-> sending)
        else $error("output active while idle");
    send_start_a: assert property (send_req ##0 !sending |=> sending)
        else $error("send did not start");
    stop_end_a: assert property (stop_req |=> quiet)
        else $error("stop did not end the stream");
    idle_hold_a: assert property (!sending && !(reg_write && reg_addr == 8'h00
        && reg_wdata[0]) |=> !sending)
        else $error("sending rose without send");
    status_read_a: assert property (reg_read && reg_addr == pse_pkg::pse_off_status
        |=> reg_rdata[0] == $past(sending))
        else $error("status flag wrong");
endmodule // pse_encoder_checker

bind pse_encoder pse_encoder_checker #(.fifo_depth(fifo_depth)) checker_u (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .out_active(out_active), .out_positive(out_positive),
    .out_negative(out_negative), .bit_strobe(bit_strobe), .sending(sending)
);

// File: verif/pse_pager_model.sv
// Purpose: modulation path model, records output levels per bit
// Assumes: bit_strobe stands in the first cycle of each new bit
// Notes:   lv holds 1 for positive deviation
`timescale 1ns/10ps
module pse_pager_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic out_active,
    input wire logic out_positive,
    input wire logic out_negative,
    input wire logic bit_strobe
);
    logic lv [0:1023];
    int   count;
    int   gap;
    int   last_gap;

    // the level standing beside the strobe is the bit just loaded
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count    <= 0;
            gap      <= 0;
            last_gap <= 0;
        end
        else
        begin
            gap      <= gap + 1;
            if (clear)
                count <= 0;
            else if (bit_strobe && out_active && (out_positive != out_negative))
            begin
                lv[count[9:0]] <= out_positive;
                count          <= count + 1;
                last_gap       <= gap;
                gap            <= 1;
            end
        end
    end
endmodule // pse_pager_model

// File: verif/test_paging_stream_encoder.sv
// Purpose: self-checking bench for the paging stream encoder
// Assumes: rate 0 gives one bit per clock
// Notes:   expected frames are built from the field layout
`timescale 1ns/10ps
module test_paging_stream_encoder;
    logic        clock = 1'b0;
    logic        rst_n, reg_write, reg_read, clear;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v, c;
    logic        out_active, out_positive, out_negative, bit_strobe, sending;
    int          checks = 0, fails = 0, cycles = 0, i, k;
    logic [7:0]  msg [16];
    logic [20:0] code = 21'h1a5c3f;
    int          errpos = 40;
    logic        exp_q [$];

    pse_encoder #(.fifo_depth(4)) dut_u (.clock(clock), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .out_active(out_active),
        .out_positive(out_positive), .out_negative(out_negative),
        .bit_strobe(bit_strobe), .sending(sending));
    pse_pager_model pager_u (.clock(clock), .rst_n(rst_n), .clear(clear),
        .out_active(out_active), .out_positive(out_positive),
        .out_negative(out_negative), .bit_strobe(bit_strobe));

    always #10 clock = ~clock;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clock);
    endtask

    function automatic logic [31:0] mk(input logic [1:0] md, fn, ty,
        input logic sd, iv, er, input logic [4:0] ln);
        return {15'h0, ln, 3'h0, er, iv, sd, ty, fn, md};
    endfunction

    // expected levels: preamble, address, function, characters
    task automatic build(input logic [31:0] cf, input int reps);
        int n, w, len;
        logic fr [$];
        exp_q = {};
        w = (cf[5:4] == 2'b01) ? 4 : ((cf[5:4] == 2'b10) ? 7 : 0);
        len = (w == 0) ? 0 : ((cf[16:12] > 16) ? 16 : int'(cf[16:12]));
        repeat (reps)
        begin
            fr = {};
            for (n = 0; n < 32; n++) fr.push_back(n[0] ^ cf[6]);
            for (n = 20; n >= 0; n--) fr.push_back(code[n]);
            fr.push_back(cf[3]);
            fr.push_back(cf[2]);
            for (n = 0; n < len * w; n++) fr.push_back(msg[n / w][n % w]);
            if (cf[8]) fr[errpos] = !fr[errpos];
            foreach (fr[n]) exp_q.push_back(fr[n] ^ cf[7]);
        end
    endtask

    task automatic cmp();
        foreach (exp_q[n]) check(pager_u.lv[n], exp_q[n]);
    endtask

    task automatic start(input logic [31:0] cf);
        clear <= 1'b1;
        wr(pse_pkg::pse_off_config, cf);
        clear <= 1'b0;
        wr(pse_pkg::pse_off_ctrl, 32'h1);
    endtask

    task automatic run(input logic [31:0] cf, input int reps);
        start(cf);
        rd(pse_pkg::pse_off_status, v);
        check(v[0], 1'b1);
        for (k = 0; sending !== 1'b0 && k < 3000; k++) @(posedge clock);
        repeat (4) @(posedge clock);
        #1 check(sending, 1'b0);
        rd(pse_pkg::pse_off_config, v);
        check(v, cf);
        build(cf, reps);
        check(pager_u.count, exp_q.size());
        cmp();
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst_n, reg_write, reg_read, clear, reg_addr, reg_wdata} = '0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(pse_pkg::pse_off_rate, v);
        check(v, 32'h4b0);
        rd(pse_pkg::pse_off_bursts, v);
        check(v, 32'h1);
        rd(pse_pkg::pse_off_status, v);
        check(v, 32'h0);
        rd(8'h30, v);
        check(v, 32'h0);
        wr(pse_pkg::pse_off_rate, 32'h0);
        wr(pse_pkg::pse_off_bursts, 32'h3);
        wr(pse_pkg::pse_off_address, {11'h0, code});
        wr(pse_pkg::pse_off_errbit, errpos);
        for (i = 0; i < 16; i++)
        begin
            msg[i] = 8'h13 + 8'(i * 37);
            wr(pse_pkg::pse_off_msg + 8'(4 * i), {24'h0, msg[i]});
        end
        for (i = 0; i < 4; i++) run(mk(2'b00, 2'(i), 2'b00, 0, 0, 0, 5'h3), 1);
        run(mk(2'b00, 2'b01, 2'b01, 0, 1, 0, 5'h3), 1);
        run(mk(2'b01, 2'b10, 2'b10, 1, 0, 0, 5'h11), 3);
        run(mk(2'b00, 2'b11, 2'b01, 0, 0, 1, 5'h2), 1);
        c = mk(2'b10, 2'b01, 2'b00, 0, 0, 0, 5'h0);
        start(c);
        for (k = 0; pager_u.count < 200 && k < 3000; k++) @(posedge clock);
        wr(pse_pkg::pse_off_ctrl, 32'h2);
        #1 check({sending, out_active}, 2'b00);
        k = pager_u.count;
        repeat (20) @(posedge clock);
        check(pager_u.count, k);
        build(c, 3);
        cmp();
        wr(pse_pkg::pse_off_rate, 32'd50000);
        start(mk(2'b00, 2'b00, 2'b00, 0, 0, 0, 5'h0));
        for (k = 0; pager_u.count < 3 && k < 6000; k++) @(posedge clock);
        check(pager_u.last_gap, 32'd1000);
        wr(pse_pkg::pse_off_ctrl, 32'h2);
        summarize();
    end
endmodule // test_paging_stream_encoder
